// [sim/dual_rheostat_checker.sv]
/*
  Port-level checker of the dual rheostat command unit.
  Assumes it is bound to the top module and sees only its ports.
*/
`default_nettype none

module dual_rheostat_checker (
  input wire logic                    sys_clk,           // System clock
  input wire logic                    rst,               // Asynchronous reset
  input wire logic                    chip_select_n,     // Frame select
  input wire logic                    preset_strobe_n,   // Restore strobe pin
  input wire logic                    serial_out_oe,     // Serial out enable
  input wire rheostat_pkg::wiper_type wiper_setting_ch1, // Channel 1 setting
  input wire rheostat_pkg::wiper_type wiper_setting_ch2, // Channel 2 setting
  input wire logic [1023:0]           tap_select_ch1,    // Channel 1 taps
  input wire logic [1023:0]           tap_select_ch2,    // Channel 2 taps
  input wire logic                    idle               // Idle state
);
  import rheostat_pkg::*;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_TAP_CH1:
  assert property (tap_select_ch1 == (1024'h1 << wiper_setting_ch1)) else $error("tap ch1 wrong");
  AST_TAP_CH2:
  assert property (tap_select_ch2 == (1024'h1 << wiper_setting_ch2)) else $error("tap ch2 wrong");
  AST_OUT_ENABLE:
  assert property (serial_out_oe == !chip_select_n) else $error("serial out enable wrong");
  AST_POWER_ON:
  assert property ($past(rst) |=> wiper_setting_ch1 == 10'h200 && wiper_setting_ch2 == 10'h200)
    else $error("power-on restore missing");
  AST_IN_RESET:
  assert property (disable iff (1'b0) rst |-> wiper_setting_ch1 == 10'h000 &&
    wiper_setting_ch2 == 10'h000 && idle) else $error("reset values wrong");
  // A frame only acts once complete, so a long select window is quiet
  AST_FRAME_QUIET:
  assert property ((!chip_select_n && preset_strobe_n)[*5] |->
    $stable(wiper_setting_ch1) && $stable(wiper_setting_ch2)) else $error("wiper moved in frame");
  AST_NOP_QUIET:
  assert property ($rose(idle) |-> $stable(wiper_setting_ch1) && $stable(wiper_setting_ch2))
    else $error("nop moved a wiper");
  AST_ONE_STEP:
  assert property (!$past(rst) && ($changed(wiper_setting_ch1) || $changed(wiper_setting_ch2))
    |=> ($stable(wiper_setting_ch1) && $stable(wiper_setting_ch2))[*8]) else $error("wiper ripple");
  AST_IDLE_AFTER_FRAME:
  assert property ($changed(idle) |-> chip_select_n && $past(chip_select_n))
    else $error("idle changed outside execution");
endmodule

bind dual_rheostat_serial_command_unit dual_rheostat_checker chk (
  .sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n),
  .preset_strobe_n(preset_strobe_n), .serial_out_oe(serial_out_oe),
  .wiper_setting_ch1(wiper_setting_ch1), .wiper_setting_ch2(wiper_setting_ch2),
  .tap_select_ch1(tap_select_ch1), .tap_select_ch2(tap_select_ch2), .idle(idle));

`default_nettype wire

// [sim/host_link_model.sv]
/*
  Host side of the serial link: frames of up to 24 bits, MSB first.
  Assumes the device presents the next output bit after each rising edge.
*/
`default_nettype none

module host_link_model (
  output logic      serial_clk,    // Runs only inside frames
  output logic      chip_select_n, // Low during a frame
  output logic      serial_in,     // Data to the device
  input  wire logic serial_out     // Data from the device
);
  timeunit 1ns;
  timeprecision 1ps;
  import rheostat_pkg::*;

  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end

  // Fewer than 24 bits makes an aborted frame
  task automatic xfer(input frame_type tx, input int nbits, output frame_type rx);
    rx = '0;
    #3 chip_select_n = 1'b0;
    for (int i = 23; i >= 24 - nbits; i--) begin
      serial_in = tx[i];
      #6 rx[i] = serial_out;
      serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    #3 chip_select_n = 1'b1;
    // Released line does not keep its last level
    serial_in = ~serial_in;
    // Gap well above the six system clocks the reply needs
    #100;
  endtask
endmodule

`default_nettype wire

// [sim/testbench.sv]
/*
  Self-checking bench of the command unit with a reference model.
  Assumes the host model spaces frames beyond the execution latency.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rheostat_pkg::*;

  logic          sys_clk = 1'b0;
  logic          rst = 1'b0;
  logic          preset_strobe_n = 1'b1;
  logic          write_protect_n = 1'b1;
  wire           serial_clk;
  wire           chip_select_n;
  wire           serial_in;
  logic          serial_out;
  logic          serial_out_oe;
  wiper_type     w1;
  wiper_type     w2;
  logic [1023:0] t1;
  logic [1023:0] t2;
  logic          idle;
  int            error_cnt = 0;
  int            checks = 0;
  wiper_type     ew1 = 10'h200;
  wiper_type     ew2 = 10'h200;
  nv_word_type   nv [16];
  frame_type     exp_reply = '0;
  logic          exp_idle = 1'b1;
  frame_type     rx;
  frame_type     f;
  frame_type     plan [26] = '{24'hb00100, 24'he00000, 24'he00000, 24'h200000, 24'h100000,
    24'h000000, 24'h800000, 24'h32aaaa, 24'h335555, 24'h920000, 24'h000000, 24'hb00200,
    24'hc00000, 24'ha00000, 24'h000000, 24'hb10200, 24'hc10000, 24'hb003fe, 24'he00000,
    24'he00000, 24'ha10000, 24'h9f0000, 24'h3fabcd, 24'hb10000, 24'h210000, 24'h000000};

  always #4 sys_clk = ~sys_clk;

  dual_rheostat_serial_command_unit dut (
    .sys_clk(sys_clk), .rst(rst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .preset_strobe_n(preset_strobe_n), .write_protect_n(write_protect_n),
    .wiper_setting_ch1(w1), .wiper_setting_ch2(w2), .tap_select_ch1(t1),
    .tap_select_ch2(t2), .idle(idle));

  host_link_model host (
    .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out));

  task automatic check(input frame_type seen, input frame_type exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d of %0d checks", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic wiper_type dbl(input wiper_type w);
    return (w >= 10'h200) ? 10'h3ff : {w[8:0], 1'b0};
  endfunction

  function automatic wiper_type inc(input wiper_type w);
    return (w == 10'h3ff) ? w : w + 10'h001;
  endfunction

  task automatic check_state;
    check(24'(w1), 24'(ew1));
    check(24'(w2), 24'(ew2));
    check(24'(t1[ew1]), 24'h1);
    check(24'(t2[ew2]), 24'h1);
  endtask

  task automatic run(input frame_type fr);
    frame_type  got;
    frame_type  nrep;
    nibble_type c;
    nibble_type a;
    logic       ch2;
    wiper_type  cur;
    c = fr[23:20];
    a = fr[19:16];
    ch2 = (a == 4'h1);
    cur = ch2 ? ew2 : ew1;
    nrep = fr;
    host.xfer(fr, 24, got);
    check(got, exp_reply);
    case (c)
      4'h0: exp_idle = 1'b1;
      4'h1: begin
        cur = nv[ch2][9:0];
        exp_idle = 1'b0;
      end
      4'h2: if (write_protect_n) nv[ch2] = {6'h00, cur};
      4'h3: if (write_protect_n && a != 4'hf) nv[a] = fr[15:0];
      4'h8: begin
        ew1 = nv[0][9:0];
        ew2 = nv[1][9:0];
        exp_idle = 1'b0;
      end
      4'h9: begin
        nrep = {c, a, nv[a]};
        exp_idle = 1'b0;
      end
      4'ha: begin
        nrep = {c, a, 6'h00, cur};
        exp_idle = 1'b0;
      end
      4'hb: cur = fr[9:0];
      4'hc: cur = dbl(cur);
      4'he: cur = inc(cur);
      default: ;
    endcase
    if (c inside {4'h1, 4'hb, 4'hc, 4'he}) begin
      if (ch2) ew2 = cur;
      else ew1 = cur;
    end
    exp_reply = nrep;
    check_state;
    check(24'(idle), 24'(exp_idle));
  endtask

  task automatic set_protect(input logic v);
    @(posedge sys_clk);
    #1 write_protect_n = v;
  endtask

  initial begin
    #400us;
    error_cnt++;
    complete_run;
  end

  initial begin
    void'($urandom(32'h8583));
    foreach (nv[i]) nv[i] = (i < 2) ? 16'h0200 : 16'h0000;
    // Raised after time zero so every asynchronous reset sees an edge
    #1 rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check_state;
    check(24'(idle), 24'h1);
    foreach (plan[i]) run(plan[i]);
    for (int n = 0; n < 150; n++) begin
      f = 24'($urandom);
      // Spare stores keep clear of the wiper words
      if (f[23:20] == 4'h3 && f[19:17] == 3'h0) f[17] = 1'b1;
      set_protect($urandom_range(0, 3) != 0);
      run(f);
    end
    set_protect(1'b0);
    run(24'hb00055);
    run(24'h200000);
    run(24'h331111);
    set_protect(1'b1);
    run(24'h100000);
    run(24'h930000);
    host.xfer(24'hb003aa, 10, rx);
    check_state;
    run(24'h000000);
    run(24'hb00123);
    run(24'hb10321);
    @(posedge sys_clk);
    #1 preset_strobe_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 preset_strobe_n = 1'b1;
    repeat (10) @(posedge sys_clk);
    ew1 = nv[0][9:0];
    ew2 = nv[1][9:0];
    #1 check_state;
    run(24'h000000);
    complete_run;
  end
endmodule

`default_nettype wire

// [src/dual_rheostat_serial_command_unit.sv]
/*
  Command core of a dual 1024-position programmable resistor: decodes
  serial frames, keeps both wiper settings and the nonvolatile store,
  handles preset and power-on restore. Assumes the host leaves chip select
  high for at least 6 system clocks between frames, and that write-protect
  and preset come from pins asynchronous to sys_clk.
*/
`include "rheostat_defs.svh"
`default_nettype none

// Notes on behaviour
// - Load to channel 1 writes frame's low 10 data bits into its wiper.
// - Increment to channel 1 adds one to its wiper; data ignored.
// - Store to channel 1 copies its wiper into its nonvolatile word.
// - Write-protect low blocks every command write to the nonvolatile store.
// - Power-on, preset strobe or restore command reload wipers from store.
// - Restore to channel 1 loads its nonvolatile value into its wiper.
// - NOP returns the device to idle and does nothing else.
// - Global reset command reloads both wipers from their stored values.
// - Shift-left to channel 1 doubles its wiper, saturating at 3ff.
// - Shift-left to channel 2 doubles channel 2 only.
// - User store writes 16 data bits to any addressed word but the tolerance word, 15 of them.
// - User read fetches the addressed stored word for the next frame.
// - Frame after read preparation shifts out 24 bits, data in low 16.
// - Wiper read-back returns the 10-bit setting in next frame's low bits.
// - Load addressed to channel 2 writes channel 2's wiper.
// - Power-on copies stored values into both wipers automatically.
// - Each 10-bit wiper selects exactly one of 1024 taps; zero nearest B.
module dual_rheostat_serial_command_unit (
  input  wire logic                   sys_clk,           // System clock
  input  wire logic                   rst,               // Asynchronous reset
  input  wire logic                   serial_clk,        // Serial clock from host
  input  wire logic                   chip_select_n,     // Frame select
  input  wire logic                   serial_in,         // Serial data in
  output logic                        serial_out,        // Serial data out
  output logic                        serial_out_oe,     // Drive enable, serial out
  input  wire logic                   preset_strobe_n,   // Restore strobe pin
  input  wire logic                   write_protect_n,   // Low blocks store writes
  output rheostat_pkg::wiper_type     wiper_setting_ch1, // Channel 1 setting
  output rheostat_pkg::wiper_type     wiper_setting_ch2, // Channel 2 setting
  output logic [1023:0]               tap_select_ch1,    // Channel 1 tap switches
  output logic [1023:0]               tap_select_ch2,    // Channel 2 tap switches
  output logic                        idle               // Low-power idle state
);
  import rheostat_pkg::*;

  // Saturating increment; stays at full scale
  function automatic wiper_type sat_increment(input wiper_type cur);
    sat_increment = (cur == `WIPER_FULL_SCALE) ? cur : wiper_type'(cur + 10'h001);
  endfunction

  // Doubling, 6 dB up; clamps instead of wrapping
  function automatic wiper_type sat_double(input wiper_type cur);
    sat_double = cur[`WIPER_MSB] ? `WIPER_FULL_SCALE : {cur[8:0], 1'b0};
  endfunction

  // Next setting of one channel for a command aimed at it
  function automatic wiper_type apply_command(
    input nibble_type  cmd,
    input nv_word_type data,
    input wiper_type   cur,
    input nv_word_type stored
  );
    apply_command = cur;
    unique case (cmd)
      `CMD_LOAD:       apply_command = data[`WIPER_MSB:0];
      `CMD_INCREMENT:  apply_command = sat_increment(cur);
      `CMD_SHIFT_LEFT: apply_command = sat_double(cur);
      `CMD_RESTORE:    apply_command = stored[`WIPER_MSB:0];
      default:         apply_command = cur;
    endcase
  endfunction

  // One switch on per setting; code zero is the tap at terminal B
  function automatic logic [1023:0] tap_decode(input wiper_type code);
    tap_decode       = '0;
    tap_decode[code] = 1'b1;
  endfunction

  serial_frame_if frame_bus ();

  serial_link_shifter u_link (
    .serial_clk    (serial_clk),
    .rst           (rst),
    .chip_select_n (chip_select_n),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .frame         (frame_bus.link)
  );

  // Synchronisers for the frame toggle and both pins
  logic           toggle_meta;
  logic           toggle_sync;
  logic           toggle_seen;
  logic           preset_meta;
  logic           preset_sync;
  logic           preset_prev;
  logic           protect_meta;
  logic           protect_sync;

  ctrl_state_type ctrl_state;
  ctrl_state_type next_ctrl_state;
  nv_word_type    nonvolatile_store [`NV_WORDS];
  wiper_type      next_wiper_ch1;
  wiper_type      next_wiper_ch2;
  frame_type      next_reply;
  logic           next_idle;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      toggle_meta  <= 1'b0;
      toggle_sync  <= 1'b0;
    end else begin
      toggle_meta  <= frame_bus.frame_toggle;
      toggle_sync  <= toggle_meta;
    end
  end

  // Edge detector on the crossed toggle: one strobe per frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      toggle_seen  <= 1'b0;
    end else begin
      toggle_seen  <= toggle_sync;
    end
  end

  // Preset idles high; reset values avoid a false strobe at release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      preset_meta  <= 1'b1;
      preset_sync  <= 1'b1;
      preset_prev  <= 1'b1;
    end else begin
      preset_meta  <= preset_strobe_n;
      preset_sync  <= preset_meta;
      preset_prev  <= preset_sync;
    end
  end

  // Protected until the pin has crossed, so reset never opens the store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      protect_meta <= 1'b0;
      protect_sync <= 1'b0;
    end else begin
      protect_meta <= write_protect_n;
      protect_sync <= protect_meta;
    end
  end

  // Frame decode; frame_word is stable once its toggle has crossed
  wire            frame_strobe = toggle_sync ^ toggle_seen;
  wire nibble_type rx_cmd      = frame_bus.frame_word[`CMD_MSB:`CMD_LSB];
  wire nibble_type rx_addr     = frame_bus.frame_word[`ADDR_MSB:`ADDR_LSB];
  wire nv_word_type rx_data    = frame_bus.frame_word[`DATA_MSB:`DATA_LSB];
  wire            rx_is_ch2    = (rx_addr == `ADDR_CH2);
  wire            preset_fall  = preset_prev & ~preset_sync;
  wire            power_on     = (ctrl_state == CTRL_POWER_ON);

  wire            cmd_restore_all = frame_strobe & (rx_cmd == `CMD_RESTORE_ALL);
  wire            restore_all     = power_on | preset_fall | cmd_restore_all;
  wire            cmd_store       = frame_strobe & (rx_cmd == `CMD_STORE);
  wire            cmd_user_store  = frame_strobe & (rx_cmd == `CMD_USER_STORE);
  wire            user_addr_ok    = (rx_addr != `ADDR_TOLERANCE);
  wire            store_allowed   = protect_sync;

  // Store write port: wiper save or user word
  wire            nv_write     = store_allowed &
                                 (cmd_store | (cmd_user_store & user_addr_ok));
  wire nibble_type nv_waddr    = cmd_store ? (rx_is_ch2 ? `ADDR_CH2 : `ADDR_CH1)
                                           : rx_addr;
  wire nv_word_type nv_wdata   = cmd_store
                                 ? {6'h00, (rx_is_ch2 ? wiper_setting_ch2
                                                      : wiper_setting_ch1)}
                                 : rx_data;
  wire nv_word_type nv_wiper_ch1 = nonvolatile_store[`ADDR_CH1];
  wire nv_word_type nv_wiper_ch2 = nonvolatile_store[`ADDR_CH2];

  // Power-on restore runs once, the first edge after reset release
  always_comb begin
    next_ctrl_state = CTRL_RUN;
    unique case (ctrl_state)
      CTRL_POWER_ON: next_ctrl_state = CTRL_RUN;
      CTRL_RUN:      next_ctrl_state = CTRL_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_state <= CTRL_POWER_ON;
    end else begin
      ctrl_state <= next_ctrl_state;
    end
  end

  // Restore-all outranks a frame command arriving in the same cycle
  always_comb begin
    next_wiper_ch1 = wiper_setting_ch1;
    next_wiper_ch2 = wiper_setting_ch2;
    if (restore_all) begin
      next_wiper_ch1 = nv_wiper_ch1[`WIPER_MSB:0];
      next_wiper_ch2 = nv_wiper_ch2[`WIPER_MSB:0];
    end else if (frame_strobe && !rx_is_ch2) begin
      next_wiper_ch1 = apply_command(rx_cmd, rx_data, wiper_setting_ch1, nv_wiper_ch1);
    end else if (frame_strobe) begin
      next_wiper_ch2 = apply_command(rx_cmd, rx_data, wiper_setting_ch2, nv_wiper_ch2);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wiper_setting_ch1 <= `WIPER_RESET;
      wiper_setting_ch2 <= `WIPER_RESET;
    end else begin
      wiper_setting_ch1 <= next_wiper_ch1;
      wiper_setting_ch2 <= next_wiper_ch2;
    end
  end

  // Taps follow the next value so they move with the setting registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tap_select_ch1 <= tap_decode(`WIPER_RESET);
      tap_select_ch2 <= tap_decode(`WIPER_RESET);
    end else begin
      tap_select_ch1 <= tap_decode(next_wiper_ch1);
      tap_select_ch2 <= tap_decode(next_wiper_ch2);
    end
  end

  // Store modelled in flops; a system reset reloads the default contents
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `NV_WORDS; i++) begin
        nonvolatile_store[i] <= `NV_SPARE_DEFAULT;
      end
      nonvolatile_store[`ADDR_CH1]       <= `NV_WIPER_DEFAULT;
      nonvolatile_store[`ADDR_CH2]       <= `NV_WIPER_DEFAULT;
      nonvolatile_store[`ADDR_TOLERANCE] <= `NV_TOLERANCE_WORD;
    end else if (nv_write) begin
      nonvolatile_store[nv_waddr] <= nv_wdata;
    end
  end

  // Reply for the next frame: echo, or a prepared read
  always_comb begin
    next_reply = frame_bus.reply_word;
    if (frame_strobe) begin
      unique case (rx_cmd)
        `CMD_READ_NV: begin
          next_reply = {rx_cmd, rx_addr, nonvolatile_store[rx_addr]};
        end
        `CMD_READ_WIPER: begin
          next_reply = {rx_cmd, rx_addr, 6'h00,
                        (rx_is_ch2 ? wiper_setting_ch2 : wiper_setting_ch1)};
        end
        default: begin
          next_reply = frame_bus.frame_word;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_bus.reply_word <= '0;
    end else begin
      frame_bus.reply_word <= next_reply;
    end
  end

  // Restore and read preparation leave the part busy until a NOP
  always_comb begin
    next_idle = idle;
    if (frame_strobe) begin
      unique case (rx_cmd)
        `CMD_NOP:         next_idle = 1'b1;
        `CMD_RESTORE,
        `CMD_RESTORE_ALL,
        `CMD_READ_NV,
        `CMD_READ_WIPER:  next_idle = 1'b0;
        default:          next_idle = idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle <= 1'b1;
    end else begin
      idle <= next_idle;
    end
  end
endmodule

`default_nettype wire

// [src/rheostat_defs.svh]
/*
  Constants of the dual rheostat serial command unit: frame field positions,
  command codes, address map of the nonvolatile store and reset values.
  Assumes it is included by its bare name from every file that needs it.
*/
`ifndef RHEOSTAT_DEFS_SVH
`define RHEOSTAT_DEFS_SVH

// Frame layout, most significant bit first on the wire
`define FRAME_BITS          24
`define FRAME_LAST_BIT      5'h17
`define CMD_MSB             23
`define CMD_LSB             20
`define ADDR_MSB            19
`define ADDR_LSB            16
`define DATA_MSB            15
`define DATA_LSB            0
`define WIPER_MSB           9

// Command codes in the upper nibble
`define CMD_NOP             4'h0
`define CMD_RESTORE         4'h1
`define CMD_STORE           4'h2
`define CMD_USER_STORE      4'h3
`define CMD_RESTORE_ALL     4'h8
`define CMD_READ_NV         4'h9
`define CMD_READ_WIPER      4'ha
`define CMD_LOAD            4'hb
`define CMD_SHIFT_LEFT      4'hc
`define CMD_INCREMENT       4'he

// Address nibble: channels, spare words, factory word
`define ADDR_CH1            4'h0
`define ADDR_CH2            4'h1
`define ADDR_SPARE_FIRST    4'h2
`define ADDR_SPARE_LAST     4'he
`define ADDR_TOLERANCE      4'hf
`define NV_WORDS            16

// Reset and full-scale values
`define WIPER_FULL_SCALE    10'h3ff
`define WIPER_RESET         10'h000
`define NV_WIPER_DEFAULT    16'h0200
`define NV_SPARE_DEFAULT    16'h0000
// Arbitrary value, stands in for the factory tolerance word
`define NV_TOLERANCE_WORD   16'h0000

`endif

// [src/rheostat_pkg.sv]
/*
  Types shared by the serial command unit and its link shifter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package rheostat_pkg;
  typedef logic [9:0]  wiper_type;
  typedef logic [15:0] nv_word_type;
  typedef logic [23:0] frame_type;
  typedef logic [3:0]  nibble_type;
  typedef logic [4:0]  bit_count_type;
  typedef enum logic [0:0] {
    CTRL_POWER_ON,
    CTRL_RUN
  } ctrl_state_type;
endpackage

`default_nettype wire

// [src/serial_frame_if.sv]
/*
  Carrier between the link shifter (serial clock domain) and the command
  core (system clock domain). Assumes the core owns reply_word and the
  shifter owns frame_word and frame_toggle.
*/
`default_nettype none

interface serial_frame_if;
  rheostat_pkg::frame_type frame_word;   // Last complete frame received
  logic                    frame_toggle; // Flips once per complete frame
  rheostat_pkg::frame_type reply_word;   // Word to shift out next frame

  modport link (
    output frame_word,
    output frame_toggle,
    input  reply_word
  );
  modport core (
    input  frame_word,
    input  frame_toggle,
    output reply_word
  );
endinterface

`default_nettype wire

// [src/serial_link_shifter.sv]
/*
  Serial link shifter on the host-driven serial clock. Collects 24-bit
  frames and presents the reply word on the serial output. Assumes the
  serial clock runs only inside frames and that the host keeps chip select
  high for a while between frames so the core can publish its reply.
*/
`include "rheostat_defs.svh"
`default_nettype none

module serial_link_shifter (
  input  wire logic          serial_clk,    // Serial clock from host
  input  wire logic          rst,           // Asynchronous reset
  input  wire logic          chip_select_n, // Frame select, low in frame
  input  wire logic          serial_in,     // Serial data in
  output logic               serial_out,    // Serial data out
  output logic               serial_out_oe, // Drive enable of serial_out
  serial_frame_if.link       frame          // Frame carrier to the core
);
  import rheostat_pkg::*;

  bit_count_type bit_cnt;
  logic [22:0]   shift_in;
  logic          last_bit;
  bit_count_type out_index;

  assign last_bit    = (bit_cnt == `FRAME_LAST_BIT);
  assign out_index   = bit_count_type'(`FRAME_LAST_BIT - bit_cnt);

  // Reply word is held still by the core while a frame is in flight
  assign serial_out    = frame.reply_word[out_index];
  assign serial_out_oe = ~chip_select_n;

  // No serial edges arrive between frames, so chip select clears the count;
  // reset has its own edge so the count clears even with select already high
  always_ff @(posedge serial_clk or posedge rst or posedge chip_select_n) begin
    if (rst || chip_select_n) begin
      bit_cnt <= '0;
    end else if (last_bit) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      shift_in           <= '0;
      frame.frame_word   <= '0;
      frame.frame_toggle <= 1'b0;
    end else if (!chip_select_n) begin
      shift_in <= {shift_in[21:0], serial_in};
      if (last_bit) begin
        frame.frame_word   <= {shift_in, serial_in};
        frame.frame_toggle <= ~frame.frame_toggle;
      end
    end
  end
endmodule

`default_nettype wire
